// *** prcr_pkg.sv ***
// constants and offsets for the power rail control register bank
`default_nettype none
package prcr_pkg;
   // register byte offsets on the serial register port
   localparam logic [7:0] PRCR_MAIN_CTRL_ADDR = 8'h0c;
   localparam logic [7:0] PRCR_CORE_CTRL_ADDR = 8'h0d;
   localparam logic [7:0] PRCR_LDO_CTRL_ADDR = 8'h0e;
   localparam logic [7:0] PRCR_IRQ_CFG_ADDR = 8'h0f;
   localparam logic [7:0] PRCR_IRQ_PEND_ADDR = 8'h11;
   // main converter control, low five bits only
   localparam int PRCR_MAIN_KEEP_BIT = 4;
   localparam int PRCR_MAIN_LPGATE_BIT = 3;
   localparam int PRCR_MAIN_BLEED_BIT = 2;
   localparam int PRCR_MAIN_VSEL_HI = 1;
   localparam int PRCR_MAIN_VSEL_LO = 0;
   localparam logic [4:0] PRCR_MAIN_RESET = 5'h12;
   // core converter control fields
   localparam int PRCR_CORE_OFFLP_BIT = 7;
   localparam int PRCR_CORE_VSEL_HI = 6;
   localparam int PRCR_CORE_VSEL_LO = 4;
   localparam int PRCR_CORE_LPV_HI = 3;
   localparam int PRCR_CORE_LPV_LO = 2;
   localparam int PRCR_CORE_VIB_BIT = 1;
   localparam int PRCR_CORE_BLEED_BIT = 0;
   localparam logic [7:0] PRCR_CORE_RESET = 8'h68;
   // linear regulator control fields
   localparam int PRCR_LDOB_ON_BIT = 7;
   localparam int PRCR_LDOB_SLPOFF_BIT = 6;
   localparam int PRCR_LDOB_VSEL_HI = 5;
   localparam int PRCR_LDOB_VSEL_LO = 4;
   localparam int PRCR_LDOA_ON_BIT = 3;
   localparam int PRCR_LDOA_SLPOFF_BIT = 2;
   localparam int PRCR_LDOA_VSEL_HI = 1;
   localparam int PRCR_LDOA_VSEL_LO = 0;
   localparam logic [7:0] PRCR_LDO_RESET = 8'h88;
   // gpio interrupt configuration fields
   localparam int PRCR_IRQ_EDGE_LO = 4;
   localparam int PRCR_IRQ_MASK_LO = 0;
   localparam logic [7:0] PRCR_IRQ_CFG_RESET = 8'h00;
   localparam int PRCR_GPIO_COUNT = 4;
endpackage : prcr_pkg
`default_nettype wire

// *** prcr_gpio_edge.sv ***
// one gpio edge detector with mask and sticky pending flag
`timescale 1ns/100ps
`default_nettype none
module prcr_gpio_edge (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   // pin and its configuration
   input wire logic pin_in,
   input wire logic is_output,
   input wire logic rise_sel,
   input wire logic mask,
   // host service
   input wire logic clear,
   output logic pending
);
   typedef struct packed {
      logic prev;
      logic pend;
   } prcr_edge_s;

   prcr_edge_s st_ff;
   prcr_edge_s nxt_st;
   logic rise;
   logic fall;
   logic hit;

   // edge select, then mask and direction gate
   always_comb begin
      rise = pin_in & ~st_ff.prev;
      fall = ~pin_in & st_ff.prev;
      hit = (rise_sel ? rise : fall) & ~mask & ~is_output;
      nxt_st.prev = pin_in;
      // a new edge in the clearing cycle survives the clear
      nxt_st.pend = hit | (st_ff.pend & ~clear);
   end

   // state register
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_ff <= '0;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign pending = st_ff.pend;
endmodule : prcr_gpio_edge
`default_nettype wire

// *** prcr_regs.sv ***
// power rail control register bank and rail control outputs
// How it works
// - sleep pin acts only while the low-power gate bit is set.
// - main rail discharge only when its bleed bit is set and converter off.
// - two-bit main voltage code passes to the main converter unchanged.
// - main voltage low bit loaded from strap after reset, then host writable.
// - three-bit core voltage code passes to the core converter.
// - core voltage low bit loaded from strap after reset, then writable.
// - core converter switched off in low power when its sleep-off bit set.
// - in low power core code is zero then the two sleep voltage bits.
// - leaving low power restores the full stored core voltage code.
// - vibrator transistor on exactly while its control bit is one.
// - core rail discharge when its bleed bit set and converter off.
// - regulator off when disabled; low power gives reduced or off per sleep bit.
// - regulator voltage write accepted only while that regulator is disabled.
// - both regulators reset enabled, all other regulator bits zero.
// - regulator b code: 1.8, 2.5, 2.75, 3.0 volts, reset 1.8.
// - regulator a code: adjustable, 2.5, 2.75, 3.0 volts, reset adjustable.
// - gpio edge bits choose falling when zero, rising when one.
// - gpio mask bits suppress the interrupt when one, reset unmasked.
// - pins set as outputs raise no edge interrupt.
// - low power is gate and sleep pin; no keep-alive turns both converters off.
`timescale 1ns/100ps
`default_nettype none
module prcr_regs #(
   parameter int GPIO_COUNT = prcr_pkg::PRCR_GPIO_COUNT
) (
   // clock, reset and enable
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   // register port from the serial interface
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // straps and pins
   input wire logic main_default_strap,
   input wire logic core_default_strap,
   input wire logic sleep_request_pin,
   input wire logic [GPIO_COUNT-1:0] gpio_in,
   input wire logic [GPIO_COUNT-1:0] gpio_is_output,
   // main converter controls
   output logic main_rail_enable,
   output logic main_rail_discharge,
   output logic [1:0] main_voltage_code,
   // core converter controls
   output logic core_rail_enable,
   output logic core_rail_discharge,
   output logic [2:0] core_voltage_code,
   // linear regulator controls
   output logic regulator_a_enable,
   output logic regulator_a_reduced,
   output logic [1:0] regulator_a_voltage_code,
   output logic regulator_b_enable,
   output logic regulator_b_reduced,
   output logic [1:0] regulator_b_voltage_code,
   // misc outputs
   output logic vibrator_driver_on,
   output logic low_power_active,
   output logic gpio_irq_pending
);
   import prcr_pkg::*;

   typedef struct packed {
      logic [4:0] main_ctrl;
      logic [7:0] core_ctrl;
      logic [7:0] ldo_ctrl;
      logic [7:0] irq_cfg;
      logic strap_load;
      logic [7:0] rdata;
      logic main_en;
      logic main_dis;
      logic [1:0] main_code;
      logic core_en;
      logic core_dis;
      logic [2:0] core_code;
      logic ldoa_en;
      logic ldoa_red;
      logic [1:0] ldoa_code;
      logic ldob_en;
      logic ldob_red;
      logic [1:0] ldob_code;
      logic vibrator_driver;
      logic lp;
      logic irq;
   } prcr_state_s;

   prcr_state_s st_ff;
   prcr_state_s nxt_st;
   logic [GPIO_COUNT-1:0] pend;
   logic [GPIO_COUNT-1:0] pend_clear;
   logic lp_now;
   logic main_on;
   logic core_on;
   logic [4:0] main_v;
   logic [7:0] core_v;
   logic [7:0] ldo_v;

   // per-pin edge detectors
   for (genvar g = 0; g < GPIO_COUNT; g++) begin : g_edge
      prcr_gpio_edge u_edge (
         .clock(clock),
         .rst(rst),
         .ce(ce),
         .pin_in(gpio_in[g]),
         .is_output(gpio_is_output[g]),
         .rise_sel(st_ff.irq_cfg[PRCR_IRQ_EDGE_LO + g]),
         .mask(st_ff.irq_cfg[PRCR_IRQ_MASK_LO + g]),
         .clear(pend_clear[g]),
         .pending(pend[g])
      );
   end

   // write one to clear the pending flags
   always_comb begin
      pend_clear = '0;
      if (reg_wr_en && reg_addr == PRCR_IRQ_PEND_ADDR) begin
         pend_clear = reg_wdata[GPIO_COUNT-1:0];
      end
   end

   // register writes, strap capture and rail decode
   always_comb begin
      nxt_st = st_ff;
      main_v = st_ff.main_ctrl;
      core_v = st_ff.core_ctrl;
      ldo_v = st_ff.ldo_ctrl;
      // straps are sampled on the first enabled edge after reset release
      if (st_ff.strap_load) begin
         main_v[PRCR_MAIN_VSEL_LO] = main_default_strap;
         core_v[PRCR_CORE_VSEL_LO] = core_default_strap;
         nxt_st.strap_load = 1'b0;
      end
      if (reg_wr_en) begin
         case (reg_addr)
            PRCR_MAIN_CTRL_ADDR: begin
               main_v = reg_wdata[4:0];
            end
            PRCR_CORE_CTRL_ADDR: begin
               core_v = reg_wdata;
            end
            PRCR_LDO_CTRL_ADDR: begin
               ldo_v[PRCR_LDOB_ON_BIT] = reg_wdata[PRCR_LDOB_ON_BIT];
               ldo_v[PRCR_LDOB_SLPOFF_BIT] = reg_wdata[PRCR_LDOB_SLPOFF_BIT];
               ldo_v[PRCR_LDOA_ON_BIT] = reg_wdata[PRCR_LDOA_ON_BIT];
               ldo_v[PRCR_LDOA_SLPOFF_BIT] = reg_wdata[PRCR_LDOA_SLPOFF_BIT];
               // changing a live regulator's voltage could upset its load
               if (!st_ff.ldo_ctrl[PRCR_LDOB_ON_BIT]) begin
                  ldo_v[PRCR_LDOB_VSEL_HI:PRCR_LDOB_VSEL_LO] =
                     reg_wdata[PRCR_LDOB_VSEL_HI:PRCR_LDOB_VSEL_LO];
               end
               if (!st_ff.ldo_ctrl[PRCR_LDOA_ON_BIT]) begin
                  ldo_v[PRCR_LDOA_VSEL_HI:PRCR_LDOA_VSEL_LO] =
                     reg_wdata[PRCR_LDOA_VSEL_HI:PRCR_LDOA_VSEL_LO];
               end
            end
            PRCR_IRQ_CFG_ADDR: begin
               nxt_st.irq_cfg = reg_wdata;
            end
            default: begin
            end
         endcase
      end
      nxt_st.main_ctrl = main_v;
      nxt_st.core_ctrl = core_v;
      nxt_st.ldo_ctrl = ldo_v;

      // low power mode and converter enables
      lp_now = main_v[PRCR_MAIN_LPGATE_BIT] & sleep_request_pin;
      main_on = ~(lp_now & ~main_v[PRCR_MAIN_KEEP_BIT]);
      core_on = ~(lp_now & (~main_v[PRCR_MAIN_KEEP_BIT]
                            | core_v[PRCR_CORE_OFFLP_BIT]));
      nxt_st.lp = lp_now;
      nxt_st.main_en = main_on;
      nxt_st.core_en = core_on;
      nxt_st.main_dis = main_v[PRCR_MAIN_BLEED_BIT] & ~main_on;
      nxt_st.core_dis = core_v[PRCR_CORE_BLEED_BIT] & ~core_on;
      nxt_st.main_code = main_v[PRCR_MAIN_VSEL_HI:PRCR_MAIN_VSEL_LO];
      // sleep code forces the top bit low; full code returns on exit
      if (lp_now) begin
         nxt_st.core_code = {1'b0, core_v[PRCR_CORE_LPV_HI:PRCR_CORE_LPV_LO]};
      end else begin
         nxt_st.core_code = core_v[PRCR_CORE_VSEL_HI:PRCR_CORE_VSEL_LO];
      end
      nxt_st.vibrator_driver = core_v[PRCR_CORE_VIB_BIT];

      // linear regulators
      nxt_st.ldoa_en = ldo_v[PRCR_LDOA_ON_BIT]
                       & ~(lp_now & ldo_v[PRCR_LDOA_SLPOFF_BIT]);
      nxt_st.ldoa_red = ldo_v[PRCR_LDOA_ON_BIT] & lp_now
                        & ~ldo_v[PRCR_LDOA_SLPOFF_BIT];
      nxt_st.ldob_en = ldo_v[PRCR_LDOB_ON_BIT]
                       & ~(lp_now & ldo_v[PRCR_LDOB_SLPOFF_BIT]);
      nxt_st.ldob_red = ldo_v[PRCR_LDOB_ON_BIT] & lp_now
                        & ~ldo_v[PRCR_LDOB_SLPOFF_BIT];
      nxt_st.ldoa_code = ldo_v[PRCR_LDOA_VSEL_HI:PRCR_LDOA_VSEL_LO];
      nxt_st.ldob_code = ldo_v[PRCR_LDOB_VSEL_HI:PRCR_LDOB_VSEL_LO];
      nxt_st.irq = |pend;

      // read data is registered, shows stored contents
      if (reg_rd_en) begin
         case (reg_addr)
            PRCR_MAIN_CTRL_ADDR: nxt_st.rdata = {3'h0, st_ff.main_ctrl};
            PRCR_CORE_CTRL_ADDR: nxt_st.rdata = st_ff.core_ctrl;
            PRCR_LDO_CTRL_ADDR: nxt_st.rdata = st_ff.ldo_ctrl;
            PRCR_IRQ_CFG_ADDR: nxt_st.rdata = st_ff.irq_cfg;
            PRCR_IRQ_PEND_ADDR: begin
               nxt_st.rdata = '0;
               nxt_st.rdata[GPIO_COUNT-1:0] = pend;
            end
            default: nxt_st.rdata = 8'h00;
         endcase
      end
   end

   // state register; reset values are constants, straps follow release
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_ff <= '0;
         st_ff.main_ctrl <= PRCR_MAIN_RESET;
         st_ff.core_ctrl <= PRCR_CORE_RESET;
         st_ff.ldo_ctrl <= PRCR_LDO_RESET;
         st_ff.irq_cfg <= PRCR_IRQ_CFG_RESET;
         st_ff.strap_load <= 1'b1;
         st_ff.main_en <= 1'b1;
         st_ff.core_en <= 1'b1;
         st_ff.main_code <= PRCR_MAIN_RESET[1:0];
         st_ff.core_code <= PRCR_CORE_RESET[6:4];
         st_ff.ldoa_en <= 1'b1;
         st_ff.ldob_en <= 1'b1;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   // outputs straight from the state register
   assign reg_rdata = st_ff.rdata;
   assign main_rail_enable = st_ff.main_en;
   assign main_rail_discharge = st_ff.main_dis;
   assign main_voltage_code = st_ff.main_code;
   assign core_rail_enable = st_ff.core_en;
   assign core_rail_discharge = st_ff.core_dis;
   assign core_voltage_code = st_ff.core_code;
   assign regulator_a_enable = st_ff.ldoa_en;
   assign regulator_a_reduced = st_ff.ldoa_red;
   assign regulator_a_voltage_code = st_ff.ldoa_code;
   assign regulator_b_enable = st_ff.ldob_en;
   assign regulator_b_reduced = st_ff.ldob_red;
   assign regulator_b_voltage_code = st_ff.ldob_code;
   assign vibrator_driver_on = st_ff.vibrator_driver;
   assign low_power_active = st_ff.lp;
   assign gpio_irq_pending = st_ff.irq;
endmodule : prcr_regs
`default_nettype wire

// *** prcr_regs_assertions.sv ***
// bound checker for the power rail control register bank
`timescale 1ns/100ps
`default_nettype none
module prcr_regs_assertions (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // register port
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_addr,
   // pins and rail controls
   input wire logic sleep_request_pin,
   input wire logic main_rail_enable,
   input wire logic main_rail_discharge,
   input wire logic [1:0] main_voltage_code,
   input wire logic core_rail_enable,
   input wire logic core_rail_discharge,
   input wire logic [2:0] core_voltage_code,
   input wire logic regulator_a_enable,
   input wire logic regulator_a_reduced,
   input wire logic [1:0] regulator_a_voltage_code,
   input wire logic vibrator_driver_on,
   input wire logic low_power_active,
   input wire logic gpio_irq_pending
);
   import prcr_pkg::*;
   logic [1:0] age_ff;
   // edges since reset, so the strap load is not taken for a host write
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         age_ff <= 2'h0;
      end else if (age_ff != 2'h3) begin
         age_ff <= age_ff + 2'h1;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   chk_sleep_pin: assert property (!$past(sleep_request_pin) |-> !low_power_active)
      else $error("low power without sleep pin");
   chk_main_bleed: assert property (main_rail_discharge |-> !main_rail_enable)
      else $error("main discharge while on");
   chk_core_bleed: assert property (core_rail_discharge |-> !core_rail_enable)
      else $error("core discharge while on");
   chk_sleep_code: assert property (low_power_active && $past(low_power_active) |->
      !core_voltage_code[2]) else $error("core top bit set in low power");
   chk_reg_reduced: assert property (regulator_a_reduced |-> regulator_a_enable)
      else $error("regulator reduced while off");
   // control outputs move at the write's own edge, so the write is one sample back
   chk_vib_write: assert property ($changed(vibrator_driver_on) |-> $past(reg_wr_en, 1)
      && $past(reg_addr, 1) == PRCR_CORE_CTRL_ADDR) else $error("vibrator moved unwritten");
   chk_main_write: assert property (age_ff == 2'h3 && $changed(main_voltage_code) |->
      $past(reg_wr_en, 1) && $past(reg_addr, 1) == PRCR_MAIN_CTRL_ADDR)
      else $error("main code moved unwritten");
   chk_rega_code: assert property ($changed(regulator_a_voltage_code) |->
      !$past(regulator_a_enable)) else $error("regulator code taken while on");
   chk_irq_clear: assert property ($fell(gpio_irq_pending) |-> $past(reg_wr_en, 2)
      && $past(reg_addr, 2) == PRCR_IRQ_PEND_ADDR) else $error("pending dropped unserviced");
endmodule : prcr_regs_assertions
bind prcr_regs prcr_regs_assertions u_chk (.*);
`default_nettype wire

// *** prcr_host_model.sv ***
// host model driving the register port of the power rail bank
`timescale 1ns/100ps
`default_nettype none
module prcr_host_model (
   // clock
   input wire logic clock,
   // register port
   output logic reg_wr_en,
   output logic reg_rd_en,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata
);
   // idle port at time zero
   initial begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // one access held through its sampling edge; regulator a is only raised
   // by an enabling write, since a large raise can reset the system
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      #1;
      reg_wr_en = wr;
      reg_rd_en = !wr;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clock);
      #1;
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      // released lines show the inverse so stale values are never trusted
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : xfer
endmodule : prcr_host_model
`default_nettype wire

// *** prcr_regs_tb.sv ***
// self-checking testbench for the power rail control register bank
`timescale 1ns/100ps
`default_nettype none
module prcr_regs_tb;
   import prcr_pkg::*;
   logic clock, rst, ce, reg_wr_en, reg_rd_en, main_default_strap, core_default_strap;
   logic sleep_request_pin, main_rail_enable, main_rail_discharge, core_rail_enable;
   logic core_rail_discharge, regulator_a_enable, regulator_a_reduced, regulator_b_enable;
   logic regulator_b_reduced, vibrator_driver_on, low_power_active, gpio_irq_pending, rd_d;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, lfsr;
   logic [1:0] main_voltage_code, regulator_a_voltage_code, regulator_b_voltage_code;
   logic [2:0] core_voltage_code;
   logic [3:0] gpio_in, gpio_is_output;
   logic [10:0] gcase [5];
   logic [7:0] exp_q [$];
   int failures, num_checks;
   wire logic [7:0] rails = {low_power_active, main_rail_enable, main_rail_discharge,
      core_rail_enable, core_rail_discharge, core_voltage_code};
   wire logic [7:0] regs = {4'h0, regulator_a_enable, regulator_a_reduced,
      regulator_b_enable, regulator_b_reduced};
   prcr_regs dut (.*);
   prcr_host_model host (.*);
   // free running clock
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.xfer(1'b1, a, d);
   endtask : wr
   // the expected value is noted before the read goes out
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.xfer(1'b0, a, 8'h00);
   endtask : rd
   task automatic w(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : w
   function automatic logic [7:0] step(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : step
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish
   // read data lands one edge after the strobe; take the oldest note then
   always @(posedge clock) begin
      if (rd_d) chk(reg_rdata, exp_q.pop_front());
      rd_d <= reg_rd_en;
   end
   // a hang ends the run as a mismatch
   initial begin
      #100000;
      failures++;
      tally_and_finish;
   end
   // main sequence
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      main_default_strap = 1'b1;
      core_default_strap = 1'b1;
      sleep_request_pin = 1'b0;
      gpio_in = 4'h0;
      gpio_is_output = 4'h0;
      lfsr = 8'h1a;
      rd_d = 1'b0;
      // cfg, pin is output, start level, pending expected
      gcase = '{{8'h10, 3'b001}, {8'h10, 3'b010}, {8'h00, 3'b011}, {8'h11, 3'b000},
         {8'h10, 3'b100}};
      repeat (16) @(posedge clock);
      #1;
      rst = 1'b0;
      w(2);
      rd(PRCR_MAIN_CTRL_ADDR, 8'h13);
      rd(PRCR_CORE_CTRL_ADDR, 8'h78);
      rd(PRCR_LDO_CTRL_ADDR, 8'h88);
      rd(PRCR_IRQ_CFG_ADDR, 8'h00);
      rd(8'h20, 8'h00);
      chk(rails, 8'h57);
      chk(regs, 8'h0a);
      // every core and main code, vibrator toggling alongside
      for (int i = 0; i < 8; i++) begin
         wr(PRCR_CORE_CTRL_ADDR, {1'b0, 3'(i), 2'b10, i[0], 1'b0});
         wr(PRCR_MAIN_CTRL_ADDR, {6'h04, 2'(i)});
         w(1);
         chk({4'h0, vibrator_driver_on, core_voltage_code}, {4'h0, i[0], 3'(i)});
         chk(8'(main_voltage_code), 8'(i[1:0]));
      end
      for (int i = 0; i < 4; i++) begin
         lfsr = step(lfsr);
         wr(PRCR_IRQ_CFG_ADDR, lfsr);
         rd(PRCR_IRQ_CFG_ADDR, lfsr);
      end
      // sleep pin with the gate off, then on
      sleep_request_pin = 1'b1;
      wr(PRCR_CORE_CTRL_ADDR, 8'hf5);
      w(3);
      chk(rails, 8'h57);
      wr(PRCR_MAIN_CTRL_ADDR, 8'h08);
      w(3);
      chk(rails, 8'h89);
      chk(regs, 8'h0f);
      wr(PRCR_MAIN_CTRL_ADDR, 8'h0c);
      w(2);
      chk(rails, 8'ha9);
      sleep_request_pin = 1'b0;
      w(3);
      chk(rails, 8'h57);
      wr(PRCR_LDO_CTRL_ADDR, 8'hcc);
      sleep_request_pin = 1'b1;
      w(3);
      chk(regs, 8'h00);
      sleep_request_pin = 1'b0;
      // voltage refused while on, taken with the enabling write
      wr(PRCR_LDO_CTRL_ADDR, 8'h8b);
      rd(PRCR_LDO_CTRL_ADDR, 8'h88);
      wr(PRCR_LDO_CTRL_ADDR, 8'h80);
      wr(PRCR_LDO_CTRL_ADDR, 8'h8e);
      rd(PRCR_LDO_CTRL_ADDR, 8'h8e);
      chk(8'(regulator_a_voltage_code), 8'h02);
      // regulator b off, then its code rides in with the enabling write
      wr(PRCR_LDO_CTRL_ADDR, 8'h08);
      wr(PRCR_LDO_CTRL_ADDR, 8'hb8);
      rd(PRCR_LDO_CTRL_ADDR, 8'hba);
      chk({4'h0, regulator_b_voltage_code, regulator_a_voltage_code}, 8'h0e);
      // gpio edge cases; pending cleared before each edge
      foreach (gcase[i]) begin
         gpio_is_output = {3'h0, gcase[i][2]};
         gpio_in = {3'h0, gcase[i][1]};
         wr(PRCR_IRQ_CFG_ADDR, gcase[i][10:3]);
         wr(PRCR_IRQ_PEND_ADDR, 8'h0f);
         w(3);
         chk(8'(gpio_irq_pending), 8'h00);
         gpio_in = {3'h0, ~gcase[i][1]};
         w(4);
         chk(8'(gpio_irq_pending), 8'(gcase[i][0]));
         rd(PRCR_IRQ_PEND_ADDR, 8'(gcase[i][0]));
      end
      // frozen enable drops the write
      ce = 1'b0;
      wr(PRCR_CORE_CTRL_ADDR, 8'h00);
      w(2);
      chk(rails, 8'h57);
      ce = 1'b1;
      rd(PRCR_CORE_CTRL_ADDR, 8'hf5);
      // let the read be checked before reset clears the read data
      w(1);
      // second reset with both straps low
      rst = 1'b1;
      main_default_strap = 1'b0;
      core_default_strap = 1'b0;
      w(3);
      rst = 1'b0;
      w(2);
      rd(PRCR_MAIN_CTRL_ADDR, 8'h12);
      rd(PRCR_CORE_CTRL_ADDR, 8'h68);
      chk(rails, 8'h56);
      w(3);
      tally_and_finish;
   end
endmodule : prcr_regs_tb
`default_nettype wire
